// ---- sra_map.svh ----
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH

// ********************************************************
// register indices reached through the command byte
// ********************************************************
`define SRA_CFG_IDX      8'h40
`define SRA_ADDR_IDX     8'h4C

// ********************************************************
// configuration field positions and reset values
// ********************************************************
`define SRA_CFG_SWRST    7
`define SRA_CFG_RST      8'h00
`define SRA_REG_RST      8'h00

// ********************************************************
// bus constants
// ********************************************************
`define SRA_ARA_ADDR     7'h0C
`define SRA_BYTE_LAST    4'h7
`define SRA_BYTE_BITS    4'h8

`endif

// ---- sra_pkg.sv ----
package sra_pkg;

	typedef enum logic [6:0] {
		SRA_IDLE  = 7'h01,
		SRA_ADDR  = 7'h02,
		SRA_CMD   = 7'h04,
		SRA_WDATA = 7'h08,
		SRA_ACK   = 7'h10,
		SRA_RDATA = 7'h20,
		SRA_RACK  = 7'h40
	} sra_state_e;

	typedef struct packed {
		logic       we;
		logic [7:0] idx;
		logic [7:0] data;
	} sra_wr_s;

endpackage : sra_pkg

// ---- sra_reg_bank.sv ----
`timescale 1ns/1ps
`include "sra_map.svh"

module sra_reg_bank (
	input  wire logic            clk_sys,
	input  wire logic            srst,
	input  wire logic            ce,
	input  wire sra_pkg::sra_wr_s wr,
	input  wire logic [7:0]      rdIdx,
	output logic      [7:0]      rdData,
	output logic      [7:0]      cfg
);

	logic [7:0] mem [0:255];
	logic       softRst;

	function automatic logic [7:0] regDefault(input logic [7:0] idx);
		regDefault = (idx == `SRA_CFG_IDX) ? `SRA_CFG_RST : `SRA_REG_RST;
	endfunction : regDefault

	// a write of the reset bit is never stored: the whole bank reloads instead
	assign softRst = wr.we && (wr.idx == `SRA_CFG_IDX) && wr.data[`SRA_CFG_SWRST];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= regDefault(8'(i));
			end
		end else if (ce) begin
			if (softRst) begin
				for (int i = 0; i < 256; i++) begin
					mem[i] <= regDefault(8'(i));
				end
			end else if (wr.we) begin
				mem[wr.idx] <= wr.data;
			end
		end
	end

	assign rdData = mem[rdIdx];
	assign cfg    = mem[`SRA_CFG_IDX];

endmodule : sra_reg_bank

// ---- sra_i2c_slave.sv ----
`timescale 1ns/1ps
`include "sra_map.svh"

// Operation
// - writing one to configuration bit 7 reloads every bank register default; a written slave address is kept
// - the reset bit itself returns to zero and reads back cleared
// - write byte: address+write, command byte, data byte stored at command
// - receive byte returns register chosen by last command byte
// - alert query is receive byte to 0001 100; alerting devices answer
// - 8-bit command register indexes all later register accesses

module sra_i2c_slave (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic [6:0] addrStrap,
	input  wire logic       alertActive,
	output logic      [7:0] cfgOut
);

	// ********************************************************
	// line sampling and bus events
	// ********************************************************
	logic sclQ;
	logic sdaQ;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else if (ce) begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
		end
	end

	assign sclRise   = sclIn && !sclQ;
	assign sclFall   = !sclIn && sclQ;
	assign startSeen = sclIn && sclQ && sdaQ && !sdaIn;
	assign stopSeen  = sclIn && sclQ && !sdaQ && sdaIn;

	// ********************************************************
	// state and shift registers
	// ********************************************************
	sra_pkg::sra_state_e state_q;
	sra_pkg::sra_state_e nextAfterAck_q;
	logic [3:0]          bitCnt_q;
	logic [7:0]          rxShift_q;
	logic [7:0]          txShift_q;
	logic [7:0]          cmdPtr_q;
	logic [6:0]          myAddr_q;
	logic                addrOvr_q;
	logic                ackOn_q;
	logic                ackDrive_q;
	logic [7:0]          rxByte;
	logic                byteDone;
	logic [7:0]          bankRd;
	logic [7:0]          bankCfg;
	sra_pkg::sra_wr_s    wr;

	assign rxByte   = {rxShift_q[6:0], sdaIn};
	assign byteDone = sclRise && (bitCnt_q == `SRA_BYTE_LAST);

	function automatic logic addrHit(input logic [7:0] b, input logic [6:0] a, input logic rd);
		addrHit = (b[7:1] == a) && (b[0] == rd);
	endfunction : addrHit

	// ********************************************************
	// register bank
	// ********************************************************
	always_comb begin
		wr.we   = ce && (state_q == sra_pkg::SRA_WDATA) && byteDone;
		wr.idx  = cmdPtr_q;
		wr.data = rxByte;
	end

	sra_reg_bank uBank (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ce      (ce),
		.wr      (wr),
		.rdIdx   (cmdPtr_q),
		.rdData  (bankRd),
		.cfg     (bankCfg)
	);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cfgOut <= `SRA_CFG_RST;
		end else if (ce) begin
			cfgOut <= bankCfg;
		end
	end

	// ********************************************************
	// slave address: strap caught at each start unless overwritten
	// ********************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			myAddr_q  <= 7'h00;
			addrOvr_q <= 1'b0;
		end else if (ce) begin
			if (wr.we && (wr.idx == `SRA_ADDR_IDX)) begin
				myAddr_q  <= rxByte[6:0];
				addrOvr_q <= 1'b1;
			end else if (startSeen && !addrOvr_q) begin
				myAddr_q <= addrStrap;
			end
		end
	end

	// ********************************************************
	// command pointer
	// ********************************************************
	// survives between transactions so receive byte reuses it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cmdPtr_q <= 8'h00;
		end else if (ce && (state_q == sra_pkg::SRA_CMD) && byteDone) begin
			cmdPtr_q <= rxByte;
		end
	end

	// ********************************************************
	// protocol engine
	// ********************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q        <= sra_pkg::SRA_IDLE;
			nextAfterAck_q <= sra_pkg::SRA_IDLE;
			bitCnt_q       <= 4'h0;
			rxShift_q      <= 8'h00;
			txShift_q      <= 8'h00;
			ackOn_q        <= 1'b0;
			ackDrive_q     <= 1'b0;
			sdaOe          <= 1'b0;
			sdaOut         <= 1'b0;
		end else if (ce) begin
			sdaOut <= 1'b0;
			if (startSeen) begin
				state_q  <= sra_pkg::SRA_ADDR;
				bitCnt_q <= 4'h0;
				ackOn_q  <= 1'b0;
				sdaOe    <= 1'b0;
			end else if (stopSeen) begin
				state_q <= sra_pkg::SRA_IDLE;
				ackOn_q <= 1'b0;
				sdaOe   <= 1'b0;
			end else begin
				case (state_q)
				sra_pkg::SRA_IDLE: begin
					sdaOe <= 1'b0;
				end
				sra_pkg::SRA_ADDR, sra_pkg::SRA_CMD, sra_pkg::SRA_WDATA: begin
					if (sclRise) begin
						rxShift_q <= rxByte;
						bitCnt_q  <= bitCnt_q + 4'h1;
					end
					if (byteDone) begin
						bitCnt_q   <= 4'h0;
						state_q    <= sra_pkg::SRA_ACK;
						ackDrive_q <= 1'b1;
						case (state_q)
						sra_pkg::SRA_ADDR: begin
							if (addrHit(rxByte, myAddr_q, 1'b0)) begin
								nextAfterAck_q <= sra_pkg::SRA_CMD;
							end else if (addrHit(rxByte, myAddr_q, 1'b1)) begin
								nextAfterAck_q <= sra_pkg::SRA_RDATA;
								txShift_q      <= bankRd;
							end else if (addrHit(rxByte, `SRA_ARA_ADDR, 1'b1)
								&& alertActive) begin
								nextAfterAck_q <= sra_pkg::SRA_RDATA;
								txShift_q      <= {myAddr_q, 1'b0};
							end else begin
								ackDrive_q     <= 1'b0;
								nextAfterAck_q <= sra_pkg::SRA_IDLE;
							end
						end
						sra_pkg::SRA_CMD: begin
							nextAfterAck_q <= sra_pkg::SRA_WDATA;
						end
						default: begin
							nextAfterAck_q <= sra_pkg::SRA_IDLE;
						end
						endcase
					end
				end
				sra_pkg::SRA_ACK: begin
					if (sclFall) begin
						if (!ackOn_q) begin
							ackOn_q <= 1'b1;
							sdaOe   <= ackDrive_q;
						end else begin
							ackOn_q  <= 1'b0;
							bitCnt_q <= 4'h0;
							state_q  <= nextAfterAck_q;
							// the first read bit goes out on the same fall that ends the ack
							sdaOe    <= (nextAfterAck_q == sra_pkg::SRA_RDATA) && !txShift_q[7];
						end
					end
				end
				sra_pkg::SRA_RDATA: begin
					if (sclRise) begin
						bitCnt_q <= bitCnt_q + 4'h1;
						// a released one read back as zero means another slave won
						if (txShift_q[7] && !sdaIn) begin
							state_q <= sra_pkg::SRA_IDLE;
						end
					end
					if (sclFall) begin
						if (bitCnt_q == `SRA_BYTE_BITS) begin
							sdaOe   <= 1'b0;
							state_q <= sra_pkg::SRA_RACK;
						end else begin
							txShift_q <= {txShift_q[6:0], 1'b0};
							sdaOe     <= !txShift_q[6];
						end
					end
				end
				sra_pkg::SRA_RACK: begin
					if (sclRise) begin
						if (sdaIn) begin
							state_q <= sra_pkg::SRA_IDLE;
						end else begin
							txShift_q      <= bankRd;
							state_q        <= sra_pkg::SRA_ACK;
							nextAfterAck_q <= sra_pkg::SRA_RDATA;
							ackOn_q        <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= sra_pkg::SRA_IDLE;
					sdaOe   <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule : sra_i2c_slave

// ---- sra_i2c_slave_props.sv ----
`timescale 1ns/1ps
// ****
// port checks
// ****
module sra_props (
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic       sclIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic [7:0] cfgOut
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	reset_clear_a: assert property ($fell(srst) |-> cfgOut == 8'h00 && !sdaOe)
		else $error("outputs not cleared by reset");
	open_drain_a: assert property (sdaOut == 1'b0)
		else $error("data line driven high");
	swrst_self_clear_a: assert property (!cfgOut[7])
		else $error("reset request bit seen set");
	cfg_update_a: assert property ($changed(cfgOut) |-> $past(sclIn) && $past(sclIn, 2))
		else $error("configuration changed outside a data bit");
	ack_launch_a: assert property ($rose(sdaOe) |-> $past(sclIn, 2) && !$past(sclIn))
		else $error("drive started off the clock fall");
	drive_release_a: assert property ($fell(sdaOe) |-> !$past(sclIn))
		else $error("drive released while clock high");
	hold_high_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
		else $error("data moved while clock high");
endmodule : sra_props

bind sra_i2c_slave sra_props u_props (.clk_sys(clk_sys), .srst(srst), .sclIn(sclIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .cfgOut(cfgOut));

// ---- sra_host_model.sv ----
`timescale 1ns/1ps
// ****
// bus host
// ****
module sra_host_model (
	input  wire logic clk_sys,
	input  wire logic devOe,
	output logic      sclIn,
	output logic      sdaIn
);
	logic hostOe = 1'b0;
	// pulled-up wire: a released line reads high, never a stale value
	assign sdaIn = !(hostOe | devOe);
	initial sclIn = 1'b1;
	task automatic hw(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : hw
	// four clocks per phase, above the two the slave needs
	task automatic bitx(input logic b, output logic r);
		hostOe = !b;
		hw(3);
		sclIn = 1'b1;
		hw(4);
		r = sdaIn;
		sclIn = 1'b0;
		hw(1);
	endtask : bitx
	task automatic start();
		hostOe = 1'b0;
		hw(2);
		sclIn = 1'b1;
		hw(4);
		hostOe = 1'b1;
		hw(4);
		sclIn = 1'b0;
		hw(1);
	endtask : start
	task automatic stop();
		hostOe = 1'b1;
		hw(2);
		sclIn = 1'b1;
		hw(4);
		hostOe = 1'b0;
		hw(4);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic hostAck, output logic [7:0] r,
		output logic devAck);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(!hostAck, a);
		devAck = !a;
	endtask : xfer
endmodule : sra_host_model

// ---- serial_register_access_soft_reset_tb.sv ----
`timescale 1ns/1ps
module serial_register_access_soft_reset_tb;
	logic       clk_sys     = 1'b0;
	logic       srst        = 1'b1;
	logic       alertActive = 1'b0;
	logic       ce          = 1'b1;
	logic [6:0] addrStrap   = 7'h2A;
	logic       sclIn, sdaIn, sdaOut, sdaOe;
	logic [7:0] cfgOut, c, d;
	int         fails  = 0;
	int         checks = 0;
	int         seed   = 97521;
	int         mdl[256];
	initial forever #12.5 clk_sys = !clk_sys;
	sra_host_model h (.clk_sys(clk_sys), .devOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
	sra_i2c_slave u_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap),
		.alertActive(alertActive), .cfgOut(cfgOut));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			fails++;
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// mode 0 send byte, 1 write byte, 2 command then repeated start
	task automatic wr(input logic [7:0] cm, input logic [7:0] dt, input int mode);
		logic [7:0] r;
		logic a;
		h.start();
		h.xfer({addrStrap, 1'b0}, 1'b0, r, a);
		chk("address ack", 8'h01, {7'h00, a});
		h.xfer(cm, 1'b0, r, a);
		if (mode == 1) begin
			h.xfer(dt, 1'b0, r, a);
			if (cm == 8'h40 && dt[7]) begin
				foreach (mdl[i]) mdl[i] = 0;
			end else begin
				mdl[cm] = dt;
			end
		end
		if (mode != 2) begin
			h.stop();
		end
		chk("cfg image", 8'(mdl[64]), cfgOut);
	endtask : wr
	task automatic rcv(input logic [6:0] ad, input logic [7:0] e, input logic ea);
		logic [7:0] r;
		logic a;
		h.start();
		h.xfer({ad, 1'b1}, 1'b0, r, a);
		chk("read ack", {7'h00, ea}, {7'h00, a});
		if (a) begin
			h.xfer(8'hFF, 1'b0, r, a);
			chk("read data", e, r);
		end
		h.stop();
	endtask : rcv
	initial begin
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		for (int k = 0; k < 4; k++) begin
			c = 8'($random(seed)) & 8'h3F;
			d = 8'($random(seed));
			wr(c, d, 1);
			wr(c, 8'h00, 2);
			rcv(addrStrap, 8'(mdl[c]), 1'b1);
		end
		rcv(addrStrap, 8'(mdl[c]), 1'b1);
		$display("register access test done");
		wr(8'h40, d & 8'h7F, 1);
		rcv(addrStrap, 8'(mdl[64]), 1'b1);
		wr(8'h40, d | 8'h80, 1);
		rcv(addrStrap, 8'h00, 1'b1);
		wr(c, 8'h00, 2);
		rcv(addrStrap, 8'h00, 1'b1);
		$display("soft reset test done");
		@(negedge clk_sys);
		alertActive = 1'b1;
		rcv(7'h0C, {addrStrap, 1'b0}, 1'b1);
		alertActive = 1'b0;
		rcv(7'h0C, 8'h00, 1'b0);
		rcv(addrStrap ^ 7'h01, 8'h00, 1'b0);
		// a frozen slave must not answer even its own address
		ce = 1'b0;
		rcv(addrStrap, 8'h00, 1'b0);
		ce = 1'b1;
		$display("alert and address test done");
		wr(8'h4C, 8'h33, 1);
		rcv(7'(mdl[76]), 8'(mdl[76]), 1'b1);
		rcv(addrStrap, 8'h00, 1'b0);
		// only a full reset drops the written address; it also reloads the bank, as a soft reset does
		@(negedge clk_sys);
		srst = 1'b1;
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		foreach (mdl[i]) mdl[i] = 0;
		rcv(addrStrap, 8'(mdl[0]), 1'b1);
		$display("address override and reset test done");
		give_verdict();
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		fails++;
		give_verdict();
	end
endmodule : serial_register_access_soft_reset_tb
